// ### design/torque_inhibit_regs.svh
// Timing constants of the dual-channel torque-inhibit monitor
`ifndef TORQUE_INHIBIT_REGS_SVH
`define TORQUE_INHIBIT_REGS_SVH
// Clock period in ns
`define TI_CLK_PERIOD_NS 100
// Longest test pulse that must be ignored, in ms
`define TI_TEST_PULSE_MS 2
// Time a channel must stay at a new level before it is acted on, in ms
`define TI_FILT_MS 6
// Mismatch fault detection times in ms: never below, nominal, always above
`define TI_MISMATCH_MIN_MS 1600
`define TI_MISMATCH_NOM_MS 2300
`define TI_MISMATCH_MAX_MS 3000
// Nanoseconds per millisecond
`define TI_NS_PER_MS 1000000
`endif

// ### design/torque_inhibit_pkg.sv
// Types shared by the torque-inhibit monitor
package torque_inhibit_pkg;
    typedef enum logic [1:0] {
        ST_STOPPED,
        ST_RUNNING,
        ST_FAULT
    } drive_state_e;
endpackage

// ### design/chan_filter_if.sv
// Carrier between a channel filter and the monitor core
`timescale 1ns/1ps
`default_nettype none
interface chan_filter_if;
    logic raw;
    logic filtered;
    modport filt (input raw, output filtered);
    modport user (output raw, input filtered);
endinterface
`default_nettype wire

// ### design/chan_filter.sv
// Level filter for one inhibit channel input
`timescale 1ns/1ps
`default_nettype none
module chan_filter #(
    parameter int CYC = 60000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Channel
    chan_filter_if.filt ch
);
    localparam int CW = $clog2(CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(CYC - 1);

    logic filt_r;
    logic filt_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    // Follow the raw level only once it has held for the whole window;
    // shorter test pulses never reach the count end
    always_comb begin
        filt_nxt = filt_r;
        cnt_nxt = '0;
        if (ch.raw != filt_r) begin
            if (cnt_r == LAST) begin
                filt_nxt = ch.raw;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    // Filtered level resets low, so the drive starts inhibited
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            filt_r <= 1'b0;
            cnt_r <= '0;
        end else begin
            filt_r <= filt_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign ch.filtered = filt_r;

    a_filt_fall_wait: assert property (@(posedge clk) disable iff (rst)
        $fell(filt_r) |-> $past(cnt_r) == LAST && !$past(ch.raw))
        else $error("filtered channel fell before the hold time");
    a_filt_pulse_gap: assert property (@(posedge clk) disable iff (rst)
        (filt_r && !ch.raw) ##1 ch.raw |=> filt_r)
        else $error("short low pulse reached the filtered channel");
endmodule
`default_nettype wire

// ### design/dual_channel_torque_inhibit.sv
// Dual-channel torque-inhibit monitor with mismatch fault latch
`timescale 1ns/1ps
`default_nettype none
`include "torque_inhibit_regs.svh"
module dual_channel_torque_inhibit
    import torque_inhibit_pkg::*;
#(
    parameter int FILT_CYC = `TI_FILT_MS * (`TI_NS_PER_MS / `TI_CLK_PERIOD_NS),
    parameter int MIS_MIN_CYC = `TI_MISMATCH_MIN_MS * (`TI_NS_PER_MS / `TI_CLK_PERIOD_NS),
    parameter int MIS_NOM_CYC = `TI_MISMATCH_NOM_MS * (`TI_NS_PER_MS / `TI_CLK_PERIOD_NS),
    parameter int MIS_MAX_CYC = `TI_MISMATCH_MAX_MS * (`TI_NS_PER_MS / `TI_CLK_PERIOD_NS)
) (
    // Clock and power-on reset
    input wire logic clk,
    input wire logic rst,
    // Inhibit channel inputs, high means run permitted
    input wire logic inhibit_in_chan_a,
    input wire logic inhibit_in_chan_b,
    // Drive software and supply status
    input wire logic sw_run_req,
    input wire logic mains_present,
    // Drive control
    output var logic power_enable,
    output var logic drive_running,
    output var logic trip,
    output var logic fault_latched,
    // Isolated safe status output pair
    output var logic safe_status_out_pos,
    output var logic safe_status_out_neg
);
    import torque_inhibit_pkg::*;

    localparam int MW = $clog2(MIS_MAX_CYC + 1);
    localparam logic [MW-1:0] MIS_LAST = MW'(MIS_NOM_CYC - 1);
    // FILT_CYC must stay above the longest test pulse; nothing here enforces it

    // Channel filters
    chan_filter_if ch_a ();
    chan_filter_if ch_b ();
    assign ch_a.raw = inhibit_in_chan_a;
    assign ch_b.raw = inhibit_in_chan_b;

    chan_filter #(.CYC(FILT_CYC)) u_filt_a (
        .clk (clk),
        .rst (rst),
        .ch  (ch_a)
    );
    chan_filter #(.CYC(FILT_CYC)) u_filt_b (
        .clk (clk),
        .rst (rst),
        .ch  (ch_b)
    );

    logic fa;
    logic fb;
    assign fa = ch_a.filtered;
    assign fb = ch_b.filtered;

    // True when the two filtered channels disagree
    function automatic logic disagree(input logic a, input logic b);
        return a ^ b;
    endfunction

    // Mismatch timer
    logic [MW-1:0] mis_cnt_r;
    logic [MW-1:0] mis_cnt_nxt;
    logic mis_hit;

    // Count only while channels disagree; agreement restarts from zero
    // The fault fires at the nominal count, inside the min..max band
    always_comb begin
        mis_hit = 1'b0;
        mis_cnt_nxt = '0;
        if (disagree(fa, fb)) begin
            if (mis_cnt_r == MIS_LAST) begin
                mis_hit = 1'b1;
                mis_cnt_nxt = mis_cnt_r;
            end else begin
                mis_cnt_nxt = mis_cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mis_cnt_r <= '0;
        end else begin
            mis_cnt_r <= mis_cnt_nxt;
        end
    end

    // Drive state and outputs
    drive_state_e state_r;
    drive_state_e state_nxt;
    logic permit;
    logic trip_r;
    logic trip_nxt;
    logic pwr_r;
    logic pwr_nxt;
    logic status_r;
    logic status_nxt;
    logic fault_r;
    logic fault_nxt;
    logic status_neg_r;
    logic status_neg_nxt;

    // Hardware permit: software can never bypass it
    assign permit = fa && fb && (state_r != ST_FAULT);

    // Trip sets on a blocked start or a drop while running; it clears once
    // software withdraws the run request, and a new set wins over that clear
    always_comb begin
        state_nxt = state_r;
        trip_nxt = trip_r && sw_run_req;
        case (state_r)
            ST_STOPPED: begin
                if (sw_run_req) begin
                    if (permit) begin
                        state_nxt = ST_RUNNING;
                    end else begin
                        trip_nxt = 1'b1;
                    end
                end
            end
            ST_RUNNING: begin
                if (!permit) begin
                    state_nxt = ST_STOPPED;
                    trip_nxt = 1'b1;
                end else if (!sw_run_req) begin
                    state_nxt = ST_STOPPED;
                end
            end
            ST_FAULT: begin
                state_nxt = ST_FAULT; // Only a power cycle leaves
                if (sw_run_req) begin
                    trip_nxt = 1'b1;
                end
            end
            default: begin
                state_nxt = ST_FAULT;
            end
        endcase
        if (mis_hit) begin
            if (state_r == ST_RUNNING || sw_run_req) begin
                trip_nxt = 1'b1;
            end
            state_nxt = ST_FAULT;
        end
    end

    // Status depends on the channels and fault only, never on mains
    // Every output pin comes from a flop (power_enable and drive_running share pwr_r), so no decode glitch reaches a pin
    always_comb begin
        pwr_nxt = (state_nxt == ST_RUNNING);
        fault_nxt = (state_nxt == ST_FAULT);
        status_nxt = !fa && !fb && (state_nxt != ST_FAULT);
        status_neg_nxt = !status_nxt;
    end

    // Reset stands for full power removal, the only way out of the fault
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_STOPPED;
            trip_r <= 1'b0;
            pwr_r <= 1'b0;
            status_r <= 1'b0;
            fault_r <= 1'b0;
            status_neg_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            trip_r <= trip_nxt;
            pwr_r <= pwr_nxt;
            status_r <= status_nxt;
            fault_r <= fault_nxt;
            status_neg_r <= status_neg_nxt;
        end
    end

    assign power_enable = pwr_r;
    assign drive_running = pwr_r;
    assign trip = trip_r;
    assign fault_latched = fault_r;
    assign safe_status_out_pos = status_r;
    assign safe_status_out_neg = status_neg_r;

    // Checks
    a_run_needs_both: assert property (@(posedge clk) disable iff (rst)
        power_enable |-> $past(fa) && $past(fb) && !fault_latched)
        else $error("power enabled without both channels high");
    a_low_blocks_pwr: assert property (@(posedge clk) disable iff (rst)
        (!fa || !fb) |=> !power_enable)
        else $error("power enabled while a channel is low");
    a_blocked_start_trip: assert property (@(posedge clk) disable iff (rst)
        (state_r == ST_STOPPED && sw_run_req && !permit) |=> trip && !power_enable)
        else $error("blocked start did not trip");
    a_status_follows: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |-> safe_status_out_pos == (!$past(fa) && !$past(fb) && !fault_latched))
        else $error("status output does not match channels");
    a_status_no_mains: assert property (@(posedge clk) disable iff (rst)
        ($changed(mains_present) && $stable(fa) && $stable(fb) && !mis_hit)
        |=> $stable(safe_status_out_pos))
        else $error("status output moved with mains");
    a_fault_not_early: assert property (@(posedge clk) disable iff (rst)
        $rose(fault_latched) |-> $past(mis_cnt_r) == MIS_LAST
        && int'($past(mis_cnt_r)) >= MIS_MIN_CYC - 1)
        else $error("fault raised before minimum mismatch time");
    a_fault_by_max: assert property (@(posedge clk) disable iff (rst)
        mis_hit |=> fault_latched && ($past(mis_cnt_r) < MW'(MIS_MAX_CYC)))
        else $error("mismatch outlived maximum detection time");
    a_fault_sticky: assert property (@(posedge clk) disable iff (rst)
        fault_latched |=> (fault_latched && !power_enable) [*2])
        else $error("fault state was left without power cycle");
    a_mis_restart: assert property (@(posedge clk) disable iff (rst)
        (fa == fb) |=> mis_cnt_r == '0)
        else $error("mismatch timer kept counting after agreement");

    c_run: cover property (@(posedge clk) disable iff (rst) $rose(power_enable));
    c_trip_running: cover property (@(posedge clk) disable iff (rst)
        power_enable ##1 !power_enable && trip);
    c_fault: cover property (@(posedge clk) disable iff (rst) $rose(fault_latched));
    c_safe_state: cover property (@(posedge clk) disable iff (rst) $rose(safe_status_out_pos));
endmodule
`default_nettype wire

// ### sim/safety_ctrl_model.sv
// Behavioural model of the external safety controller feeding both channels
`timescale 1ns/1ps
`default_nettype none
module safety_ctrl_model #(
    parameter int SKEW = 3,
    parameter int PULSE_CYC = 6
) (
    // Clock
    input wire logic clk,
    // Requested channel levels and test pulse request
    input wire logic want_a,
    input wire logic want_b,
    input wire logic pulse_a,
    // Channel outputs, always driven like relay contacts to a supply
    output var logic chan_a,
    output var logic chan_b
);
    logic [15:0] b_dly;
    int pulse_cnt;

    initial begin
        b_dly = '0;
        pulse_cnt = 0;
        chan_a = 1'b0;
        chan_b = 1'b0;
    end

    // Channel B lags A by a few cycles, as two relay sets never switch together
    always @(posedge clk) begin
        b_dly <= {b_dly[14:0], want_b};
        chan_b <= b_dly[SKEW-1];
        // Short low-going test pulse on A, kept below the filter span
        if (pulse_a && pulse_cnt == 0) begin
            pulse_cnt <= PULSE_CYC;
        end else if (pulse_cnt > 0) begin
            pulse_cnt <= pulse_cnt - 1;
        end
        chan_a <= want_a && !(pulse_cnt > 0);
    end
endmodule
`default_nettype wire

// ### sim/tb_dual_channel_torque_inhibit.sv
// Self-checking bench for the dual-channel torque-inhibit monitor
`timescale 1ns/1ps
`default_nettype none
module tb_dual_channel_torque_inhibit;
    localparam int FILT = 8;
    localparam int MIN_C = 40;
    localparam int NOM_C = 50;
    localparam int MAX_C = 64;
    localparam int SETTLE = FILT + 3 + 6;
    logic clk, rst, want_a, want_b, pulse_a, sw_run_req, mains_present;
    logic chan_a, chan_b, power_enable, drive_running, trip, fault_latched, pos, neg;
    int err_total, total_checks;

    safety_ctrl_model #(.SKEW(3), .PULSE_CYC(FILT - 2)) partner_u (.clk(clk), .want_a(want_a),
        .want_b(want_b), .pulse_a(pulse_a), .chan_a(chan_a), .chan_b(chan_b));
    dual_channel_torque_inhibit #(.FILT_CYC(FILT), .MIS_MIN_CYC(MIN_C), .MIS_NOM_CYC(NOM_C),
        .MIS_MAX_CYC(MAX_C)) dut_u (.clk(clk), .rst(rst), .inhibit_in_chan_a(chan_a),
        .inhibit_in_chan_b(chan_b), .sw_run_req(sw_run_req), .mains_present(mains_present),
        .power_enable(power_enable), .drive_running(drive_running), .trip(trip),
        .fault_latched(fault_latched), .safe_status_out_pos(pos), .safe_status_out_neg(neg));

    // Free-running clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Outputs are judged at the falling edge, well clear of the launching edge
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic drv(input logic a, input logic b, input logic req);
        @(posedge clk);
        want_a <= a;
        want_b <= b;
        sw_run_req <= req;
    endtask

    task automatic check_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_out(input logic pe, input logic tr, input logic fl, input logic st);
        check_bit(power_enable, pe);
        check_bit(drive_running, pe);
        check_bit(trip, tr);
        check_bit(fault_latched, fl);
        check_bit(pos, st);
        check_bit(neg, ~st);
    endtask

    task automatic t_reset();
        cyc(2);
        check_out(1'b0, 1'b0, 1'b0, 1'b1);
    endtask

    // Run, ignore a short test pulse, then a genuine drop on channel A
    task automatic t_run();
        drv(1'b1, 1'b1, 1'b0);
        cyc(SETTLE);
        check_out(1'b0, 1'b0, 1'b0, 1'b0);
        drv(1'b1, 1'b1, 1'b1);
        cyc(2);
        check_out(1'b1, 1'b0, 1'b0, 1'b0);
        drv(1'b1, 1'b1, 1'b0);
        cyc(2);
        check_out(1'b0, 1'b0, 1'b0, 1'b0);
        drv(1'b1, 1'b1, 1'b1);
        cyc(2);
        check_out(1'b1, 1'b0, 1'b0, 1'b0);
        @(posedge clk);
        pulse_a <= 1'b1;
        @(posedge clk);
        pulse_a <= 1'b0;
        cyc(SETTLE);
        check_out(1'b1, 1'b0, 1'b0, 1'b0);
        drv(1'b0, 1'b1, 1'b1);
        cyc(FILT);
        check_out(1'b1, 1'b0, 1'b0, 1'b0);
        cyc(4);
        check_out(1'b0, 1'b1, 1'b0, 1'b0);
        drv(1'b1, 1'b1, 1'b0);
        cyc(SETTLE);
        check_out(1'b0, 1'b0, 1'b0, 1'b0);
    endtask

    // Two short mismatches whose sum exceeds the nominal time
    task automatic t_restart();
        repeat (2) begin
            drv(1'b1, 1'b0, 1'b0);
            cyc(30);
            check_out(1'b0, 1'b0, 1'b0, 1'b0);
            drv(1'b1, 1'b1, 1'b0);
            cyc(SETTLE);
        end
        check_bit(fault_latched, 1'b0);
    endtask

    // Auxiliary supply only: status follows, start attempt trips
    task automatic t_aux();
        @(posedge clk);
        mains_present <= 1'b0;
        drv(1'b0, 1'b0, 1'b0);
        cyc(SETTLE);
        check_out(1'b0, 1'b0, 1'b0, 1'b1);
        drv(1'b0, 1'b0, 1'b1);
        cyc(2);
        check_out(1'b0, 1'b1, 1'b0, 1'b1);
        drv(1'b0, 1'b0, 1'b0);
        mains_present <= 1'b1;
        cyc(2);
        check_bit(trip, 1'b0);
    endtask

    // Sustained mismatch latches a fault that only a power cycle clears
    task automatic t_fault();
        drv(1'b1, 1'b0, 1'b0);
        cyc(MIN_C);
        check_bit(fault_latched, 1'b0);
        cyc(MAX_C - MIN_C + FILT + 4);
        check_out(1'b0, 1'b0, 1'b1, 1'b0);
        drv(1'b1, 1'b1, 1'b1);
        cyc(SETTLE);
        check_out(1'b0, 1'b1, 1'b1, 1'b0);
        drv(1'b0, 1'b0, 1'b0);
        cyc(SETTLE);
        check_out(1'b0, 1'b0, 1'b1, 1'b0);
        @(posedge clk);
        rst <= 1'b1;
        cyc(2);
        @(posedge clk);
        rst <= 1'b0;
        cyc(2);
        check_out(1'b0, 1'b0, 1'b0, 1'b1);
    endtask

    task automatic final_report();
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Main sequence, reset held for 12 cycles
    initial begin
        err_total = 0;
        total_checks = 0;
        rst = 1'b1;
        want_a = 1'b0;
        want_b = 1'b0;
        pulse_a = 1'b0;
        sw_run_req = 1'b0;
        mains_present = 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_run();
        t_restart();
        t_aux();
        t_fault();
        final_report();
    end

    // Watchdog: the whole sequence needs well under 1000 cycles
    initial begin
        #(5000 * 100);
        err_total++;
        final_report();
    end
endmodule
`default_nettype wire
